// ===== shared/dpllrc_pkg.sv
/*
  Shared constants and carrier types for the reference mode controller of the
  on-chip digital phase-locked loop. Assumes a single 10 MHz system clock.
*/
package dpllrc_pkg;

  localparam int NUM_REF   = 4;
  localparam int CLK_HZ    = 10000000;

  // Loop control register bits.
  localparam int LCR_IRM_BIT = 0;
  localparam int LCR_FPE_BIT = 1;

  // Preference mode select encodings.
  localparam logic [2:0] PMS_ROUND_ROBIN = 3'h0;
  localparam logic [2:0] PMS_PREFERRED   = 3'h1;
  localparam logic [2:0] PMS_FORCED_REF  = 3'h2;
  localparam logic [2:0] PMS_HOLDOVER    = 3'h3;
  localparam logic [2:0] PMS_FREERUN     = 3'h4;

  // Reference frequency codes.
  localparam logic [2:0] FREQ_8K     = 3'h0;
  localparam logic [2:0] FREQ_1M544  = 3'h1;
  localparam logic [2:0] FREQ_2M048  = 3'h2;
  localparam logic [2:0] FREQ_4M096  = 3'h3;
  localparam logic [2:0] FREQ_8M192  = 3'h4;
  localparam logic [2:0] FREQ_16M384 = 3'h5;
  localparam logic [2:0] FREQ_19M44  = 3'h6;
  localparam logic [2:0] FREQ_NONE   = 3'h7;

  // Clock output three and four selections, frame pulse three widths.
  localparam logic [1:0] CK3_4M096  = 2'h0;
  localparam logic [1:0] CK3_8M192  = 2'h1;
  localparam logic [1:0] CK3_16M384 = 2'h2;
  localparam logic [1:0] CK3_32M768 = 2'h3;
  localparam logic       CK4_1M544  = 1'h0;
  localparam logic       CK4_2M048  = 1'h1;
  localparam logic [1:0] FP3_244NS  = 2'h0;
  localparam logic [1:0] FP3_122NS  = 2'h1;
  localparam logic [1:0] FP3_61NS   = 2'h2;
  localparam logic [1:0] FP3_30NS   = 2'h3;

  // Timing.
  localparam int LOCK_STEP_US  = 4000;
  localparam int LOCK_STEP_CYC = LOCK_STEP_US * (CLK_HZ / 1000000);
  localparam int HOLD_STORE_US = 32000;
  localparam int HOLD_STORE_CYC = HOLD_STORE_US * (CLK_HZ / 1000000);
  localparam int FRAME_HZ      = 8000;
  localparam int FRAME_CYC     = CLK_HZ / FRAME_HZ;

  // Frequency offset in parts per billion, bounded by the pull-in range.
  localparam int OFF_W          = 20;
  localparam int PULL_RANGE_PPM = 260;
  localparam logic signed [OFF_W-1:0] OFF_LIMIT = OFF_W'(PULL_RANGE_PPM * 1000);
  localparam logic signed [OFF_W-1:0] OFF_RESET = 20'sh00000;

  typedef enum logic [1:0] {ST_RESET, ST_FREERUN, ST_NORMAL, ST_HOLDOVER} dpllrc_state_t;

  typedef struct packed {
    logic [1:0]       loop_ctrl;
    logic [2:0]       pms;
    logic [1:0]       pref_ref;
    logic [3:0][2:0]  ref_freq_prog;
    logic [15:0]      lock_thr;
    logic [7:0]       lock_int;
    logic [1:0]       clk3_sel;
    logic             clk4_sel;
    logic [1:0]       fp3_sel;
  } dpllrc_cfg_t;

  typedef struct packed {
    logic             locked;
    logic             holdover;
    logic             freerun;
    logic             in_reset;
    logic [1:0]       active_ref;
    logic [2:0]       sel_freq;
    logic [3:0][2:0]  all_freq;
  } dpllrc_status_t;

  typedef struct packed {
    logic             out_en;
    logic [1:0]       clk3_sel;
    logic             clk4_sel;
    logic [1:0]       fp3_sel;
  } dpllrc_outcfg_t;

endpackage

// ===== hw/dpllrc_core.sv
/*
  Reference mode controller of the digital phase-locked loop: mode state machine,
  reference selection, frequency offset tracking with holdover memory, lock detection,
  frequency reporting and output clock configuration with the 8 kHz frame tick.
  Assumes the reference monitors, frequency detectors and phase detector run on i_clk,
  and that configuration ports come from registers on the same clock.
*/
`timescale 1ns/10ps
module dpllrc_core #(
  parameter int PHASE_W        = 16,
  parameter int LOCK_STEP_CYC  = dpllrc_pkg::LOCK_STEP_CYC,
  parameter int HOLD_STORE_CYC = dpllrc_pkg::HOLD_STORE_CYC
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  input  wire dpllrc_pkg::dpllrc_cfg_t        i_cfg,
  input  wire logic [3:0]                     i_ref_valid,
  input  wire logic [3:0][2:0]                i_ref_freq_det,
  input  wire logic signed [PHASE_W-1:0]      i_phase_err,
  output logic signed [dpllrc_pkg::OFF_W-1:0] o_freq_offset,
  output dpllrc_pkg::dpllrc_status_t          o_status,
  output dpllrc_pkg::dpllrc_outcfg_t          o_out_cfg,
  output logic                                o_frame_pulse
);

  localparam int OFF_W = dpllrc_pkg::OFF_W;

  if (PHASE_W < 2 || PHASE_W > OFF_W) begin : g_chk_phase
    $error("PHASE_W must lie between 2 and OFF_W");
  end
  if (LOCK_STEP_CYC < 1 || HOLD_STORE_CYC < 1) begin : g_chk_cyc
    $error("Cycle counts must be at least one");
  end

  // Search the three following references in circular order, then the current one.
  function automatic logic [2:0] next_valid(input logic [1:0] cur, input logic [3:0] ok);
    logic [1:0] idx;
    next_valid = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      idx = cur + 2'(i);
      if (ok[idx]) begin
        next_valid = {1'b1, idx};
      end
    end
  endfunction

  function automatic logic [PHASE_W-1:0] abs_err(input logic signed [PHASE_W-1:0] e);
    abs_err = e[PHASE_W-1] ? PHASE_W'(-e) : PHASE_W'(e);
  endfunction

  // Tracking adds the phase error and saturates at the pull-in range.
  function automatic logic signed [OFF_W-1:0] track(input logic signed [OFF_W-1:0] off,
                                                    input logic signed [PHASE_W-1:0] e);
    logic signed [OFF_W:0] sum;
    sum = (OFF_W+1)'(off) + (OFF_W+1)'(e);
    if (sum > (OFF_W+1)'(dpllrc_pkg::OFF_LIMIT)) begin
      track = dpllrc_pkg::OFF_LIMIT;
    end else if (sum < -(OFF_W+1)'(dpllrc_pkg::OFF_LIMIT)) begin
      track = -dpllrc_pkg::OFF_LIMIT;
    end else begin
      track = OFF_W'(sum);
    end
  endfunction

  logic                        irm;
  logic [3:0][2:0]             eff_freq;
  logic [3:0]                  usable;
  dpllrc_pkg::dpllrc_state_t   state_q;
  dpllrc_pkg::dpllrc_state_t   state_d;
  logic [1:0]                  ref_q;
  logic [1:0]                  ref_d;
  logic signed [OFF_W-1:0]     hist_new_q;
  logic signed [OFF_W-1:0]     hist_old_q;
  logic [31:0]                 store_cnt_q;
  logic [31:0]                 step_cnt_q;
  logic                        step_tick;
  logic                        window_ok_q;
  logic [7:0]                  good_cnt_q;
  logic                        locked_q;
  logic [15:0]                 frame_cnt_q;

  assign irm = i_cfg.loop_ctrl[dpllrc_pkg::LCR_IRM_BIT];

  // A reference whose frequency is not one of the seven accepted codes is skipped by round robin and preferred selection; forced reference still selects it.
  for (genvar r = 0; r < dpllrc_pkg::NUM_REF; r++) begin : g_ref
    assign eff_freq[r] = i_cfg.loop_ctrl[dpllrc_pkg::LCR_FPE_BIT] ?
                         i_cfg.ref_freq_prog[r] : i_ref_freq_det[r];
    assign usable[r]   = i_ref_valid[r] && (eff_freq[r] != dpllrc_pkg::FREQ_NONE);
  end

  always_comb begin
    logic [2:0] nv;
    logic [1:0] sec;
    nv      = next_valid(ref_q, usable);
    sec     = i_cfg.pref_ref + 2'h1;
    state_d = state_q;
    ref_d   = ref_q;
    if (irm) begin
      state_d = dpllrc_pkg::ST_RESET;
      ref_d   = 2'h0;
    end else begin
      unique case (i_cfg.pms)
        dpllrc_pkg::PMS_ROUND_ROBIN: begin
          if (usable[ref_q]) begin
            state_d = dpllrc_pkg::ST_NORMAL;
          end else if (nv[2]) begin
            state_d = dpllrc_pkg::ST_NORMAL;
            ref_d   = nv[1:0];
          end else begin
            state_d = dpllrc_pkg::ST_HOLDOVER;
          end
        end
        dpllrc_pkg::PMS_PREFERRED: begin
          if (usable[i_cfg.pref_ref]) begin
            state_d = dpllrc_pkg::ST_NORMAL;
            ref_d   = i_cfg.pref_ref;
          end else if (usable[sec]) begin
            state_d = dpllrc_pkg::ST_NORMAL;
            ref_d   = sec;
          end else begin
            state_d = dpllrc_pkg::ST_HOLDOVER;
            ref_d   = i_cfg.pref_ref;
          end
        end
        dpllrc_pkg::PMS_FORCED_REF: begin
          state_d = dpllrc_pkg::ST_NORMAL;
          ref_d   = i_cfg.pref_ref;
        end
        dpllrc_pkg::PMS_HOLDOVER: begin
          state_d = dpllrc_pkg::ST_HOLDOVER;
        end
        default: begin
          state_d = dpllrc_pkg::ST_FREERUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= dpllrc_pkg::ST_RESET;
      ref_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      ref_q   <= ref_d;
    end
  end

  // Offset: tracked in normal, restored on holdover entry, zero in freerun and reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_freq_offset <= dpllrc_pkg::OFF_RESET;
    end else begin
      unique case (state_d)
        dpllrc_pkg::ST_NORMAL:   o_freq_offset <= track(o_freq_offset, i_phase_err);
        dpllrc_pkg::ST_HOLDOVER: begin
          if (state_q != dpllrc_pkg::ST_HOLDOVER) begin
            o_freq_offset <= hist_old_q;
          end
        end
        dpllrc_pkg::ST_FREERUN:  o_freq_offset <= dpllrc_pkg::OFF_RESET;
        dpllrc_pkg::ST_RESET:    o_freq_offset <= dpllrc_pkg::OFF_RESET;
      endcase
    end
  end

  // Two-deep history: the older entry predates the last store, so a reference that
  // degrades just before failing has not yet polluted the value restored in holdover.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || irm) begin
      store_cnt_q <= 32'h0;
      hist_new_q  <= dpllrc_pkg::OFF_RESET;
      hist_old_q  <= dpllrc_pkg::OFF_RESET;
    end else if (state_q == dpllrc_pkg::ST_NORMAL) begin
      if (store_cnt_q == 32'(HOLD_STORE_CYC - 1)) begin
        store_cnt_q <= 32'h0;
        hist_new_q  <= o_freq_offset;
        hist_old_q  <= hist_new_q;
      end else begin
        store_cnt_q <= store_cnt_q + 32'h1;
      end
    end
  end

  assign step_tick = (step_cnt_q == 32'(LOCK_STEP_CYC - 1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || irm) begin
      step_cnt_q <= 32'h0;
    end else if (step_tick) begin
      step_cnt_q <= 32'h0;
    end else begin
      step_cnt_q <= step_cnt_q + 32'h1;
    end
  end

  // Lock detector; a reference switch or leaving normal restarts the qualification.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || irm || state_q != dpllrc_pkg::ST_NORMAL || ref_d != ref_q) begin
      window_ok_q <= 1'b1;
      good_cnt_q  <= 8'h0;
      locked_q    <= 1'b0;
    end else begin
      if (step_tick) begin
        window_ok_q <= 1'b1;
        if (window_ok_q && abs_err(i_phase_err) < i_cfg.lock_thr) begin
          good_cnt_q <= (good_cnt_q == 8'hff) ? good_cnt_q : good_cnt_q + 8'h1;
        end else begin
          good_cnt_q <= 8'h0;
        end
      end else if (abs_err(i_phase_err) >= i_cfg.lock_thr) begin
        window_ok_q <= 1'b0;
      end
      locked_q <= (good_cnt_q >= i_cfg.lock_int);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_status <= '0;
    end else begin
      o_status.locked     <= locked_q && (state_d == dpllrc_pkg::ST_NORMAL);
      o_status.holdover   <= (state_d == dpllrc_pkg::ST_HOLDOVER);
      o_status.freerun    <= (state_d == dpllrc_pkg::ST_FREERUN);
      o_status.in_reset   <= (state_d == dpllrc_pkg::ST_RESET);
      o_status.active_ref <= ref_d;
      o_status.sel_freq   <= eff_freq[ref_d];
      o_status.all_freq   <= eff_freq;
    end
  end

  // All outputs derive from one synthesiser, so they stay mutually synchronous.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_out_cfg <= '0;
    end else begin
      o_out_cfg.out_en   <= !irm;
      o_out_cfg.clk3_sel <= i_cfg.clk3_sel;
      o_out_cfg.clk4_sel <= i_cfg.clk4_sel;
      o_out_cfg.fp3_sel  <= i_cfg.fp3_sel;
    end
  end

  // Frame tick at 8 kHz; pulse widths below one system period belong to the synthesiser.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || irm) begin
      frame_cnt_q   <= 16'h0;
      o_frame_pulse <= 1'b0;
    end else if (frame_cnt_q == 16'(dpllrc_pkg::FRAME_CYC - 1)) begin
      frame_cnt_q   <= 16'h0;
      o_frame_pulse <= 1'b1;
    end else begin
      frame_cnt_q   <= frame_cnt_q + 16'h1;
      o_frame_pulse <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_irm_stops_outputs;
    irm |=> !o_out_cfg.out_en && !o_frame_pulse && o_status.in_reset;
  endproperty
  a_irm_stops_outputs: assert property (p_irm_stops_outputs)
    else $error("Outputs still active in internal reset");

  property p_irm_clears_offset;
    irm ##1 irm |-> o_freq_offset == 0 && !o_status.locked;
  endproperty
  a_irm_clears_offset: assert property (p_irm_clears_offset)
    else $error("Loop not held reset in internal reset mode");

  property p_force_holdover;
    !irm && i_cfg.pms == dpllrc_pkg::PMS_HOLDOVER |=> o_status.holdover &&
      (o_freq_offset == $past(o_freq_offset) || $past(state_q) != dpllrc_pkg::ST_HOLDOVER);
  endproperty
  a_force_holdover: assert property (p_force_holdover)
    else $error("Forced holdover not entered or offset moved");

  property p_freerun_zero;
    !irm && i_cfg.pms == dpllrc_pkg::PMS_FREERUN |=> o_status.freerun && o_freq_offset == 0;
  endproperty
  a_freerun_zero: assert property (p_freerun_zero)
    else $error("Freerun offset not zero");

  property p_pref_pair;
    !irm && i_cfg.pms == dpllrc_pkg::PMS_PREFERRED |=>
      o_status.active_ref == $past(i_cfg.pref_ref) ||
      o_status.active_ref == $past(i_cfg.pref_ref) + 2'h1;
  endproperty
  a_pref_pair: assert property (p_pref_pair)
    else $error("Preferred mode selected a third reference");

  property p_rr_next;
    !irm && i_cfg.pms == dpllrc_pkg::PMS_ROUND_ROBIN && !usable[ref_q] && usable[ref_q + 2'h1]
      |=> ref_q == $past(ref_q) + 2'h1 && o_status.active_ref == ref_q;
  endproperty
  a_rr_next: assert property (p_rr_next)
    else $error("Round robin skipped the next valid reference");

  property p_hold_restore;
    state_q == dpllrc_pkg::ST_NORMAL && state_d == dpllrc_pkg::ST_HOLDOVER
      |=> o_freq_offset == $past(hist_old_q) ##1 o_freq_offset == $past(o_freq_offset);
  endproperty
  a_hold_restore: assert property (p_hold_restore)
    else $error("Holdover did not restore the older stored offset");

  property p_offset_range;
    o_freq_offset <= dpllrc_pkg::OFF_LIMIT && o_freq_offset >= -dpllrc_pkg::OFF_LIMIT;
  endproperty
  a_offset_range: assert property (p_offset_range)
    else $error("Offset beyond pull-in range");

  property p_frame_spacing;
    o_frame_pulse |=> !o_frame_pulse [*8];
  endproperty
  a_frame_spacing: assert property (p_frame_spacing)
    else $error("Frame pulses too close together");

  property p_lock_normal;
    o_status.locked |-> state_q == dpllrc_pkg::ST_NORMAL &&
      $past(good_cnt_q, 2) >= $past(i_cfg.lock_int, 2);
  endproperty
  a_lock_normal: assert property (p_lock_normal)
    else $error("Lock reported without qualification in normal mode");

  property p_freq_source;
    1'b1 |=> o_status.all_freq == $past(eff_freq) && o_status.sel_freq == $past(eff_freq[ref_d]);
  endproperty
  a_freq_source: assert property (p_freq_source)
    else $error("Reported frequencies differ from their source");

endmodule

// ===== test/dpllrc_ref_src.sv
/*
  Model of the reference side of the loop controller: four monitored reference
  sources with frequency detectors and a stand-in phase detector whose error is
  the set bias plus random jitter, with no reference or feedback compared.
  Assumes the bench sets the wanted source state at rising edges of i_clk.
*/
`timescale 1ns/10ps
module dpllrc_ref_src (
  input  wire logic               i_clk,
  input  wire logic [3:0]         i_valid,
  input  wire logic [3:0][2:0]    i_freq,
  input  wire logic signed [15:0] i_bias,
  input  wire logic [7:0]         i_jit,
  output logic [3:0]              o_ref_valid,
  output logic [3:0][2:0]         o_ref_freq_det,
  output logic signed [15:0]      o_phase_err
);
  // Jitter is redrawn every cycle, so a loop that samples late sees no steady value unless i_jit is zero.
  function automatic int jitter(input logic [7:0] a);
    int j;
    j = int'($urandom % (2 * int'(a) + 1)) - int'(a);
    return j;
  endfunction

  // Monitors report one cycle after the source changes, as real ones lag.
  always @(posedge i_clk) begin
    o_ref_valid    <= i_valid;
    o_ref_freq_det <= i_freq;
    o_phase_err    <= 16'(int'(i_bias) + jitter(i_jit));
  end
endmodule

// ===== test/tb_dpll_reference_mode_control.sv
/*
  Self-checking bench of the loop reference mode controller, with the reference
  source model on its input side.
  Assumes a 10 MHz clock and shortened lock step and holdover store periods.
*/
`timescale 1ns/10ps
module tb_dpll_reference_mode_control;
  logic                               i_clk;
  logic                               i_rst_n;
  dpllrc_pkg::dpllrc_cfg_t            cfg;
  dpllrc_pkg::dpllrc_status_t         st;
  dpllrc_pkg::dpllrc_outcfg_t         ocfg;
  logic signed [dpllrc_pkg::OFF_W-1:0] o_off;
  logic                               o_fp;
  logic [3:0]                         valid;
  logic [3:0]                         rv;
  logic [3:0][2:0]                    freq;
  logic [3:0][2:0]                    rf;
  logic signed [15:0]                 bias;
  logic signed [15:0]                 perr;
  logic [7:0]                         jit;
  logic                               nx_fpe;
  logic                               nx_irm;
  logic [3:0][2:0]                    nx_det;
  logic [3:0][2:0]                    nx_prog;
  int                                 miscompares;
  int                                 total_checks;

  dpllrc_core #(.PHASE_W(16), .LOCK_STEP_CYC(16), .HOLD_STORE_CYC(8)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_ref_valid(rv), .i_ref_freq_det(rf),
    .i_phase_err(perr), .o_freq_offset(o_off), .o_status(st), .o_out_cfg(ocfg),
    .o_frame_pulse(o_fp));

  dpllrc_ref_src src (
    .i_clk(i_clk), .i_valid(valid), .i_freq(freq), .i_bias(bias), .i_jit(jit),
    .o_ref_valid(rv), .o_ref_freq_det(rf), .o_phase_err(perr));

  always #50 i_clk = ~i_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask

  // Everything the bench changes lands at one rising edge.
  task automatic apply(input logic [2:0] pms, input logic [1:0] pref, input logic [3:0] v);
    @(posedge i_clk);
    cfg.pms           <= pms;
    cfg.pref_ref      <= pref;
    cfg.loop_ctrl     <= {nx_fpe, nx_irm};
    cfg.ref_freq_prog <= nx_prog;
    valid             <= v;
    freq              <= nx_det;
    step(4);
  endtask

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask

  function automatic logic [3:0][2:0] eff();
    logic [3:0][2:0] e;
    for (int r = 0; r < 4; r++) e[r] = nx_fpe ? nx_prog[r] : nx_det[r];
    return e;
  endfunction

  function automatic logic [1:0] rr(input logic [1:0] a, input logic [3:0] u);
    logic [1:0] n;
    if (u[a]) return a;
    for (int k = 1; k < 4; k++) begin
      n = a + 2'(k);
      if (u[n]) return n;
    end
    return a;
  endfunction

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    miscompares++;
    conclude();
  end

  initial begin
    logic [1:0]      ea;
    logic [3:0]      v;
    logic [3:0]      u;
    logic [3:0][2:0] e;
    logic [1:0]      q;
    int              gap;
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    cfg = '0;
    cfg.lock_thr = 16'h0064;
    cfg.lock_int = 8'h03;
    cfg.pms = dpllrc_pkg::PMS_FORCED_REF;
    valid = 4'h0;
    freq = '0;
    bias = 16'sh0000;
    jit = 8'h00;
    nx_fpe = 1'b0;
    nx_irm = 1'b0;
    nx_det = '0;
    nx_prog = '0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(10));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Round robin with random validity and frequency settings.
    apply(dpllrc_pkg::PMS_FORCED_REF, 2'h0, 4'hf);
    apply(dpllrc_pkg::PMS_ROUND_ROBIN, 2'h0, 4'hf);
    ea = 2'h0;
    for (int i = 0; i < 24; i++) begin
      nx_fpe = 1'($urandom % 2);
      for (int r = 0; r < 4; r++) begin
        nx_det[r] = 3'($urandom % 7);
        nx_prog[r] = 3'($urandom % 7);
      end
      v = 4'(1 + $urandom % 15);
      apply(dpllrc_pkg::PMS_ROUND_ROBIN, 2'h0, v);
      e = eff();
      ea = rr(ea, v);
      check(32'(st.active_ref), 32'(ea));
      check(32'(st.sel_freq), 32'(e[ea]));
      check(32'(st.all_freq), 32'(e));
      check(32'(st.holdover), 32'h0);
    end
    // A valid reference whose frequency is unknown is skipped.
    nx_fpe = 1'b0;
    nx_det = '0;
    nx_det[1] = dpllrc_pkg::FREQ_NONE;
    apply(dpllrc_pkg::PMS_FORCED_REF, 2'h0, 4'hf);
    apply(dpllrc_pkg::PMS_ROUND_ROBIN, 2'h0, 4'he);
    check(32'(st.active_ref), 32'h2);
    apply(dpllrc_pkg::PMS_ROUND_ROBIN, 2'h0, 4'h0);
    check(32'(st.holdover), 32'h1);
    nx_det = '0;
    done("round_robin");
    // Preferred pairs, holdover when both fail, and forced selection.
    for (int p = 0; p < 4; p++) begin
      q = 2'(p);
      u = 4'hf & ~(4'h1 << q) & ~(4'h1 << (q + 2'h1));
      apply(dpllrc_pkg::PMS_PREFERRED, q, 4'hf);
      check(32'(st.active_ref), 32'(q));
      apply(dpllrc_pkg::PMS_PREFERRED, q, 4'hf & ~(4'h1 << q));
      check(32'(st.active_ref), 32'(2'(q + 2'h1)));
      apply(dpllrc_pkg::PMS_PREFERRED, q, u);
      check(32'({st.holdover, st.active_ref}), 32'({1'b1, q}));
      apply(dpllrc_pkg::PMS_FORCED_REF, q, 4'h0);
      check(32'({st.holdover, st.freerun, st.active_ref}), 32'({2'b00, q}));
    end
    done("preferred");
    // Freerun for its own code and the unused codes.
    bias = 16'sh1000;
    for (int m = 4; m < 8; m++) begin
      apply(3'(m), 2'h0, 4'hf);
      check(32'({st.freerun, st.holdover}), 32'h2);
      check(32'(o_off), 32'h0);
    end
    done("freerun");
    // Saturation, then a short dip and holdover restoring the older stored value.
    bias = 16'sh7530;
    apply(dpllrc_pkg::PMS_FORCED_REF, 2'h0, 4'hf);
    step(40);
    check(32'(o_off), 32'(dpllrc_pkg::OFF_LIMIT));
    check(32'(st.holdover), 32'h0);
    @(posedge i_clk);
    bias <= -16'sh03e8;
    step(2);
    check(32'(o_off < dpllrc_pkg::OFF_LIMIT), 32'h1);
    apply(dpllrc_pkg::PMS_HOLDOVER, 2'h0, 4'hf);
    check(32'(o_off), 32'(dpllrc_pkg::OFF_LIMIT));
    step(20);
    check(32'({st.holdover, o_off}), 32'({1'b1, dpllrc_pkg::OFF_LIMIT}));
    done("holdover");
    // Lock with quiet phase error, loss with noisy error and on leaving normal.
    @(posedge i_clk);
    bias <= 16'sh0000;
    jit <= 8'h14;
    apply(dpllrc_pkg::PMS_FORCED_REF, 2'h1, 4'hf);
    step(200);
    check(32'(st.locked), 32'h1);
    @(posedge i_clk);
    jit <= 8'hc8;
    step(100);
    check(32'(st.locked), 32'h0);
    @(posedge i_clk);
    jit <= 8'h14;
    step(200);
    check(32'(st.locked), 32'h1);
    apply(dpllrc_pkg::PMS_HOLDOVER, 2'h1, 4'hf);
    check(32'(st.locked), 32'h0);
    done("lock");
    // Output selections are handed on.
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      cfg.clk3_sel <= 2'(i);
      cfg.clk4_sel <= 1'(i);
      cfg.fp3_sel <= 2'(3 - i);
      step(3);
      check(32'(ocfg), 32'({1'b1, 2'(i), 1'(i), 2'(3 - i)}));
    end
    // Frame pulses: one cycle wide, 8 kHz apart.
    gap = 0;
    while (o_fp !== 1'b1 && gap < 3000) begin
      step(1);
      gap++;
    end
    step(1);
    check(32'(o_fp), 32'h0);
    gap = 1;
    while (o_fp !== 1'b1 && gap < 3000) begin
      step(1);
      gap++;
    end
    check(32'(gap), 32'(dpllrc_pkg::FRAME_CYC));
    done("outputs");
    // Internal reset stops the loop and keeps the settings.
    nx_irm = 1'b1;
    apply(dpllrc_pkg::PMS_FORCED_REF, 2'h2, 4'hf);
    check(32'({st.in_reset, ocfg.out_en, o_off}), 32'({2'b10, 20'h00000}));
    gap = 0;
    for (int i = 0; i < 1300; i++) begin
      step(1);
      if (o_fp !== 1'b0) gap++;
    end
    check(32'(gap), 32'h0);
    nx_irm = 1'b0;
    apply(dpllrc_pkg::PMS_FORCED_REF, 2'h2, 4'hf);
    check(32'(ocfg), 32'({1'b1, 2'h3, 1'b1, 2'h0}));
    check(32'({st.in_reset, st.active_ref}), 32'h2);
    done("internal_reset");
    conclude();
  end
endmodule
